/* design/vtap_path.sv */
// Transfer-cycle sequencing, address latches, column advance and pipelining.
// Assumes host inputs synchronous to sys_clk; memory timing (column phase,
// hold met, bank precharge) comes from the surrounding controller.
// Behaviour
// - Advance request until load end blocks refresh and second-port requests.
// - Shift load strobe asserts transfer output enable at once.
// - Enable-0 clear: transfer output enable follows the strobe.
// - Enable-0 set: release on strobe release or fourth edge.
// - Write indicator ignored by transfer logic until column strobe releases.
// - Latch mode bit picks capturing latches or permanent transparency.
// - Pulse mode: latch enable high opens, its fall captures.
// - Strobe mode: transparent until address strobe asserts, which captures.
// - Column advance increments latched column, wrapping to zero.
// - Dual port: first port latches one or two edges after grant falls.
// - Second port latches on its request, or edges after grant rises.
// - Pipelining puts next row out after hold and accepts new start.
// - Pipelining only on first port.
// - Pipelining: ack drops with access request; stall on new start.
// - Same-bank or refresh still delays the access for precharge.
// - Strobe also forces stall and holds ack inactive during transfer.
`timescale 1ns/1ps
module vtap_path
   import vtap_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic shiftLoadAdvanceRequest,
   input wire logic shiftLoadStrobe,
   input wire logic writeIndicator,
   input wire logic accessRequest,
   input wire logic addressStrobe,
   input wire logic addressLatchEnable,
   input wire logic chipSelect,
   input wire logic columnAdvance,
   input wire logic columnStrobeActive,
   input wire logic columnPhase,
   input wire logic columnHoldMet,
   input wire logic accessReady,
   input wire logic refreshInProgress,
   input wire logic refreshRequest,
   input wire logic [NUM_BANKS-1:0] bankPrecharging,
   input wire logic secondPortGrant,
   input wire logic secondPortAccessRequest,
   input wire vtap_addr_t firstPortAddr,
   input wire vtap_addr_t secondPortAddr,
   output logic transferOutputEnable,
   output logic stallOutput,
   output logic dataAckOutput,
   output logic hostAccessBusy,
   output logic refreshAllowed,
   output logic secondPortAllowed,
   output logic accessStart,
   output logic [ROW_W-1:0] memAddr,
   output vtap_addr_t latchedAddr
);
   logic [CFG_W-1:0] cfg_q;
   logic [2:0] xferCnt_q;
   logic xferExpired;
   logic xferToe;
   logic strobePrev_q;
   logic xferHold_q;
   logic wiFrozen_q;
   logic wiEff;
   logic casPrev_q;
   logic advPending_q;
   logic strobeOpen_q;
   logic transparent;
   vtap_addr_t hold_q;
   vtap_addr_t liveAddr;
   logic grantPrev_q;
   logic reqBPrev_q;
   vtap_dp_t dpState_q;
   logic dpEdge;
   logic dpLoad;
   logic pipeOn;
   logic accessPrev_q;
   logic newStart;
   logic bankBusy;
   logic [ROW_W-1:0] memAddr_d;
   logic [ROW_W-1:0] memAddr_q;

   // Register port
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cfg_q <= CFG_RESET;
      end else if (regWrite && regAddr == OFF_CONFIG) begin
         cfg_q <= regWdata[CFG_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         regRdata <= 32'h0000_0000;
      end else if (regRead) begin
         unique case (regAddr)
            OFF_CONFIG: regRdata <= {25'h000_0000, cfg_q};
            OFF_STATUS: regRdata <= {26'h000_0000, dpLoad, pipeOn, transparent,
                                     xferHold_q, hostAccessBusy, xferToe};
            OFF_ADDR: regRdata <= {8'h00, latchedAddr};
            default: regRdata <= 32'h0000_0000;
         endcase
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // Transfer cycle timer: counts rising edges since the strobe asserted
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         xferCnt_q <= 3'h0;
         strobePrev_q <= 1'b0;
      end else begin
         strobePrev_q <= shiftLoadStrobe;
         if (!shiftLoadStrobe) begin
            xferCnt_q <= 3'h0;
         end else if (xferCnt_q != XFER_EDGES) begin
            xferCnt_q <= xferCnt_q + 3'h1;
         end
      end
   end

   assign xferExpired = cfg_q[CFG_CSE0] && xferCnt_q == XFER_EDGES;
   assign xferToe = shiftLoadStrobe && !xferExpired;

   // Freeze the write indicator until the column strobe releases
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         xferHold_q <= 1'b0;
         wiFrozen_q <= 1'b0;
         casPrev_q <= 1'b0;
      end else begin
         casPrev_q <= columnStrobeActive;
         if (shiftLoadStrobe && !xferHold_q) begin
            xferHold_q <= 1'b1;
            wiFrozen_q <= writeIndicator;
         end else if (casPrev_q && !columnStrobeActive && !shiftLoadStrobe) begin
            xferHold_q <= 1'b0;
         end
      end
   end

   assign wiEff = xferHold_q ? wiFrozen_q : writeIndicator;
   // Outside transfers the line is the read output enable
   assign transferOutputEnable = xferToe
      || (!xferHold_q && accessRequest && columnStrobeActive && !wiEff);

   // Arbitration hold from advance request to the end of the load
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         advPending_q <= 1'b0;
      end else if (shiftLoadAdvanceRequest) begin
         advPending_q <= 1'b1;
      end else if (strobePrev_q && !xferToe) begin
         advPending_q <= 1'b0;
      end
   end

   assign hostAccessBusy = shiftLoadAdvanceRequest || advPending_q || xferToe;
   assign refreshAllowed = refreshRequest && !hostAccessBusy;
   assign secondPortAllowed = secondPortAccessRequest && !hostAccessBusy;

   // Strobe mode latch opening
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         strobeOpen_q <= 1'b1;
      end else if (addressStrobe) begin
         strobeOpen_q <= 1'b0;
      end else if (!accessRequest) begin
         strobeOpen_q <= 1'b1;
      end
   end

   always_comb begin
      if (!cfg_q[CFG_LATCH]) begin
         transparent = 1'b1;
      end else if (cfg_q[CFG_DUAL] && secondPortGrant) begin
         transparent = 1'b0;
      end else if (cfg_q[CFG_STROBE_MODE]) begin
         transparent = strobeOpen_q && !addressStrobe;
      end else begin
         transparent = addressLatchEnable;
      end
   end

   // Grant change that calls for a capture of the newly granted port
   assign dpEdge = cfg_q[CFG_DUAL] && grantPrev_q != secondPortGrant
      && (secondPortGrant || accessRequest);

   // Dual port capture sequencing: one extra edge when precharge select is set
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dpState_q <= DP_IDLE;
         grantPrev_q <= 1'b0;
         reqBPrev_q <= 1'b0;
      end else begin
         grantPrev_q <= secondPortGrant;
         reqBPrev_q <= secondPortAccessRequest;
         unique case (dpState_q)
            DP_IDLE: begin
               if (dpEdge && cfg_q[CFG_PSEL_LO]) begin
                  dpState_q <= DP_LOAD;
               end
            end
            DP_WAIT, DP_LOAD: dpState_q <= DP_IDLE;
         endcase
      end
   end

   // First or second edge after the grant change, per precharge select
   assign dpLoad = (dpState_q == DP_LOAD)
      || (dpState_q == DP_IDLE && dpEdge && !cfg_q[CFG_PSEL_LO])
      || (cfg_q[CFG_DUAL] && secondPortGrant && grantPrev_q
          && secondPortAccessRequest && !reqBPrev_q);

   assign liveAddr = (cfg_q[CFG_DUAL] && secondPortGrant) ? secondPortAddr
                                                          : firstPortAddr;

   // Address hold with column advance
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         hold_q <= ADDR_RESET;
      end else if (dpLoad || transparent) begin
         hold_q <= liveAddr;
      end else if (columnAdvance && !refreshInProgress) begin
         hold_q.col <= hold_q.col + 1'b1;
      end
   end

   assign latchedAddr = transparent ? liveAddr : hold_q;

   // Pipelining
   assign pipeOn = cfg_q[CFG_PIPE] && !(cfg_q[CFG_DUAL] && secondPortGrant);
   assign newStart = cfg_q[CFG_STROBE_MODE] ? addressStrobe
                                            : addressLatchEnable && chipSelect;
   assign bankBusy = bankPrecharging[latchedAddr.bank] || refreshInProgress;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         accessPrev_q <= 1'b0;
      end else begin
         accessPrev_q <= accessRequest;
      end
   end

   // New start while the current access is sustained only when pipelining
   assign accessStart = newStart && !bankBusy && !xferToe
      && (!accessPrev_q || pipeOn);

   assign stallOutput = xferToe
      || (pipeOn && newStart)
      || (accessRequest && (bankBusy || !accessReady));
   assign dataAckOutput = accessRequest && accessReady && !bankBusy
      && !xferToe && !(pipeOn && newStart);

   always_comb begin
      if (pipeOn && columnHoldMet) begin
         memAddr_d = firstPortAddr.row;
      end else if (columnPhase) begin
         memAddr_d = latchedAddr.col;
      end else begin
         memAddr_d = latchedAddr.row;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         memAddr_q <= '0;
      end else begin
         memAddr_q <= memAddr_d;
      end
   end

   assign memAddr = memAddr_q;

   // Checks
   AST_TOE_AT_ONCE: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(shiftLoadStrobe) |-> transferOutputEnable)
      else $error("transfer enable late on strobe");
   AST_TOE_FOLLOWS: assert property (@(posedge sys_clk) disable iff (reset)
      !cfg_q[CFG_CSE0] && shiftLoadStrobe |-> transferOutputEnable)
      else $error("transfer enable not following strobe");
   AST_TOE_FOURTH: assert property (@(posedge sys_clk) disable iff (reset)
      cfg_q[CFG_CSE0] && $rose(shiftLoadStrobe) ##1 shiftLoadStrobe[*3]
      ##1 (shiftLoadStrobe && $stable(cfg_q)) |-> !xferToe)
      else $error("transfer enable not released at fourth edge");
   AST_BLOCK_ARB: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(xferToe) |-> !refreshAllowed && !secondPortAllowed)
      else $error("arbiter not held after advance request");
   AST_WI_FROZEN: assert property (@(posedge sys_clk) disable iff (reset)
      xferHold_q && $stable(xferHold_q) |-> $stable(wiEff))
      else $error("write indicator reached transfer logic");
   AST_COL_INC: assert property (@(posedge sys_clk) disable iff (reset)
      !transparent && !dpLoad && columnAdvance && !refreshInProgress
      |=> hold_q.col == $past(hold_q.col) + 11'h001)
      else $error("column not advanced");
   AST_STROBE_CAPTURE: assert property (@(posedge sys_clk) disable iff (reset)
      cfg_q[CFG_LATCH] && cfg_q[CFG_STROBE_MODE] && !cfg_q[CFG_DUAL]
      && addressStrobe |-> !transparent)
      else $error("strobe did not close latch");
   AST_ACK_DROP: assert property (@(posedge sys_clk) disable iff (reset)
      !accessRequest |-> !dataAckOutput)
      else $error("ack held without access request");
   AST_PRECHARGE: assert property (@(posedge sys_clk) disable iff (reset)
      bankPrecharging[latchedAddr.bank] |-> !accessStart && !dataAckOutput)
      else $error("access not delayed for precharge");
   AST_XFER_STALL: assert property (@(posedge sys_clk) disable iff (reset)
      xferToe |-> stallOutput && !dataAckOutput)
      else $error("no wait during transfer");
endmodule

/* design/vtap_pkg.sv */
// Package for the video DRAM transfer and address path.
// Assumes one 100 MHz clock, synchronous to the video RAM shift clock.
package vtap_pkg;
   localparam int ROW_W = 11;
   localparam int COL_W = 11;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CONFIG = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ADDR = 8'h08;

   // Config field positions
   localparam int CFG_LATCH = 0;
   localparam int CFG_STROBE_MODE = 1;
   localparam int CFG_PIPE = 2;
   localparam int CFG_PSEL_LO = 3;
   localparam int CFG_PSEL_HI = 4;
   localparam int CFG_CSE0 = 5;
   localparam int CFG_DUAL = 6;
   localparam int CFG_W = 7;
   localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;

   // Transfer cycle ends at this rising edge after the strobe asserts
   localparam logic [2:0] XFER_EDGES = 3'h4;

   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
   } vtap_addr_t;

   localparam vtap_addr_t ADDR_RESET = '0;

   typedef enum logic [1:0] {
      DP_IDLE,
      DP_WAIT,
      DP_LOAD
   } vtap_dp_t;
endpackage

/* test/testbench.sv */
// Self-checking bench for the transfer and address path.
// Assumes the memory timing partner model and one 100 MHz clock.
`timescale 1ns/1ps
module testbench
   import vtap_pkg::*;
;
   logic sys_clk, reset, regWrite, regRead, adv, strobe, wrInd, accReq, addrStrobe, ale;
   logic chipSel, colAdv, refresh_in_progress, rfReq, casAct, colPhase, holdMet, accReady;
   logic toe, stall, ack, busy, rfOk, spOk, accStart;
   logic grant, spReq;
   logic [NUM_BANKS-1:0] bankPre;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, seed;
   logic [ROW_W-1:0] memAddr;
   vtap_addr_t addrIn, latched, spAddr;
   vtap_addr_t expQ[$];
   int err_count, tests_run;

   vtap_path dut (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .shiftLoadAdvanceRequest(adv), .shiftLoadStrobe(strobe), .writeIndicator(wrInd),
      .accessRequest(accReq), .addressStrobe(addrStrobe), .addressLatchEnable(ale),
      .chipSelect(chipSel), .columnAdvance(colAdv), .columnStrobeActive(casAct),
      .columnPhase(colPhase), .columnHoldMet(holdMet), .accessReady(accReady),
      .refreshInProgress(refresh_in_progress), .refreshRequest(rfReq), .bankPrecharging(bankPre),
      .secondPortGrant(grant), .secondPortAccessRequest(spReq), .firstPortAddr(addrIn),
      .secondPortAddr(spAddr), .transferOutputEnable(toe), .stallOutput(stall),
      .dataAckOutput(ack), .hostAccessBusy(busy), .refreshAllowed(rfOk),
      .secondPortAllowed(spOk), .accessStart(accStart), .memAddr(memAddr),
      .latchedAddr(latched));

   vtap_mem_model mem (.sys_clk(sys_clk), .reset(reset), .accessRequest(accReq),
      .columnStrobeActive(casAct), .columnPhase(colPhase), .columnHoldMet(holdMet),
      .accessReady(accReady));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge sys_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRead <= 1'b0;
      @(negedge sys_clk);
      chk(nm, regRdata, e);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic xfer(input logic cse0, input int len);
      logic [31:0] r;
      wr(OFF_CONFIG, cse0 ? 32'h0000_0020 : 32'h0000_0000);
      rfReq <= 1'b1;
      spReq <= 1'b1;
      @(negedge sys_clk);
      chk("refreshAllowed", rfOk, 1'b1);
      chk("secondPortAllowed", spOk, 1'b1);
      @(posedge sys_clk);
      adv <= 1'b1;
      @(negedge sys_clk);
      chk("refreshAllowed", rfOk, 1'b0);
      chk("secondPortAllowed", spOk, 1'b0);
      chk("hostAccessBusy", busy, 1'b1);
      @(posedge sys_clk);
      strobe <= 1'b1;
      @(negedge sys_clk);
      chk("toe", toe, 1'b1);
      chk("stall", stall, 1'b1);
      chk("ack", ack, 1'b0);
      for (int i = 1; i < len; i++) begin
         @(posedge sys_clk);
         r = rnd();
         wrInd <= r[0];
         accReq <= 1'b1;
         @(negedge sys_clk);
         chk("toe", toe, !cse0 || i < XFER_EDGES);
      end
      @(posedge sys_clk);
      strobe <= 1'b0;
      adv <= 1'b0;
      accReq <= 1'b0;
      @(negedge sys_clk);
      chk("toe", toe, 1'b0);
      chk("refreshAllowed", rfOk, 1'b0);
      @(negedge sys_clk);
      chk("refreshAllowed", rfOk, 1'b1);
      @(posedge sys_clk);
      rfReq <= 1'b0;
      spReq <= 1'b0;
      repeat (3) @(posedge sys_clk);
      $display("test transfer done");
   endtask

   task automatic latch_test();
      logic [31:0] r;
      vtap_addr_t a, b;
      int expCol;
      r = rnd();
      a = r[23:0];
      r = rnd();
      b = r[23:0];
      a.col = 11'h7FE;
      wr(OFF_CONFIG, 32'h0000_0000);
      ale <= 1'b1;
      addrIn <= a;
      @(posedge sys_clk);
      ale <= 1'b0;
      @(posedge sys_clk);
      addrIn <= b;
      @(negedge sys_clk);
      chk("latched", latched, b);
      wr(OFF_CONFIG, 32'h0000_0001);
      ale <= 1'b1;
      addrIn <= a;
      @(negedge sys_clk);
      chk("latched", latched, a);
      expQ.push_back(a);
      @(posedge sys_clk);
      ale <= 1'b0;
      @(posedge sys_clk);
      addrIn <= b;
      @(negedge sys_clk);
      chk("latched", latched, expQ.pop_front());
      expCol = a.col;
      for (int k = 0; k < 5; k++) begin
         @(posedge sys_clk);
         if (colAdv && !refresh_in_progress) expCol = (expCol + 1) % 2048;
         colAdv <= k < 3;
         refresh_in_progress <= k == 2;
         @(negedge sys_clk);
         chk("column", latched.col, expCol);
      end
      wr(OFF_CONFIG, 32'h0000_0003);
      addrIn <= a;
      @(negedge sys_clk);
      chk("latched", latched, a);
      @(posedge sys_clk);
      addrStrobe <= 1'b1;
      @(posedge sys_clk);
      accReq <= 1'b1;
      @(posedge sys_clk);
      addrStrobe <= 1'b0;
      @(posedge sys_clk);
      addrIn <= b;
      @(negedge sys_clk);
      chk("latched", latched, a);
      @(posedge sys_clk);
      accReq <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("latched", latched, b);
      $display("test latch done");
   endtask

   task automatic dual_test();
      logic [31:0] r;
      vtap_addr_t a, b;
      for (int p = 0; p < 2; p++) begin
         r = rnd();
         a = r[23:0];
         r = rnd();
         b = r[23:0];
         wr(OFF_CONFIG, p[0] ? 32'h0000_0049 : 32'h0000_0041);
         ale <= 1'b1;
         addrIn <= a;
         @(posedge sys_clk);
         ale <= 1'b0;
         grant <= 1'b1;
         spAddr <= b;
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk("latched", latched, p[0] ? a : b);
         @(negedge sys_clk);
         chk("latched", latched, b);
         @(posedge sys_clk);
         spReq <= 1'b1;
         spAddr <= a;
         @(negedge sys_clk);
         chk("secondPortAllowed", spOk, 1'b1);
         @(posedge sys_clk);
         spReq <= 1'b0;
         @(negedge sys_clk);
         chk("latched", latched, a);
         @(posedge sys_clk);
         grant <= 1'b0;
         accReq <= 1'b1;
         addrIn <= b;
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk("latched", latched, p[0] ? a : b);
         @(negedge sys_clk);
         chk("latched", latched, b);
         @(posedge sys_clk);
         accReq <= 1'b0;
      end
      $display("test dual done");
   endtask

   task automatic pipe_test();
      logic [31:0] r;
      vtap_addr_t a, b;
      r = rnd();
      a = r[23:0];
      r = rnd();
      b = r[23:0];
      wr(OFF_CONFIG, 32'h0000_0005);
      addrIn <= a;
      chipSel <= 1'b1;
      ale <= 1'b1;
      @(negedge sys_clk);
      chk("stall", stall, 1'b1);
      @(posedge sys_clk);
      ale <= 1'b0;
      chipSel <= 1'b0;
      accReq <= 1'b1;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("ack", ack, 1'b1);
      @(posedge sys_clk);
      ale <= 1'b1;
      chipSel <= 1'b1;
      addrIn <= b;
      @(negedge sys_clk);
      chk("accessStart", accStart, 1'b1);
      chk("stall", stall, 1'b1);
      @(posedge sys_clk);
      ale <= 1'b0;
      chipSel <= 1'b0;
      accReq <= 1'b0;
      @(negedge sys_clk);
      chk("ack", ack, 1'b0);
      chk("memAddr", memAddr, b.row);
      @(posedge sys_clk);
      bankPre <= 4'hF;
      ale <= 1'b1;
      chipSel <= 1'b1;
      @(negedge sys_clk);
      chk("accessStart", accStart, 1'b0);
      @(posedge sys_clk);
      bankPre <= 4'h0;
      ale <= 1'b0;
      chipSel <= 1'b0;
      $display("test pipeline done");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      close_out();
   end

   initial begin
      {reset, regWrite, regRead, adv, strobe, wrInd, accReq, addrStrobe} = 8'h80;
      {ale, chipSel, colAdv, refresh_in_progress, rfReq, grant, spReq} = 7'h00;
      bankPre = 4'h0;
      spAddr = ADDR_RESET;
      regAddr = 8'h00;
      regWdata = 32'h0000_0000;
      addrIn = ADDR_RESET;
      seed = 32'hc673_be2c;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      rd(OFF_CONFIG, {25'h0, CFG_RESET}, "config");
      rd(8'h0C, 32'h0000_0000, "unmapped");
      wr(OFF_CONFIG, 32'h0000_0021);
      rd(OFF_CONFIG, 32'h0000_0021, "config");
      for (int k = 0; k < 6; k++) begin
         xfer(k[0], k < 2 ? 2 : (k < 4 ? 6 : 1 + int'(rnd() % 32'd7)));
      end
      latch_test();
      dual_test();
      pipe_test();
      close_out();
   end
endmodule

/* test/vtap_mem_model.sv */
// Memory timing partner: answers each access with column phase and strobe timing.
// Assumes accessRequest comes from the host side, all in the sys_clk domain.
`timescale 1ns/1ps
module vtap_mem_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic accessRequest,
   output logic columnStrobeActive,
   output logic columnPhase,
   output logic columnHoldMet,
   output logic accessReady
);
   logic [1:0] stage_q;
   // Column strobe drops the cycle after the request is released
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage_q <= 2'h0;
      end else if (!accessRequest) begin
         stage_q <= 2'h0;
      end else if (stage_q != 2'h3) begin
         stage_q <= stage_q + 2'h1;
      end
   end
   assign columnPhase = stage_q >= 2'h1;
   assign columnStrobeActive = stage_q >= 2'h2;
   assign columnHoldMet = stage_q == 2'h3;
   assign accessReady = columnStrobeActive;
endmodule
